// >>> hdl/port_pin_alternate_mux.sv
// Three general-purpose ports with alternate-function routing
`timescale 1ns/1ps
`default_nettype none
`include "port_mux_params.svh"
module port_pin_alternate_mux
	import port_mux_pkg::*;
#(
	parameter int FIRST_W  = `FIRST_PORT_WIDTH,
	parameter int SECOND_W = `SECOND_PORT_WIDTH,
	parameter int THIRD_W  = `THIRD_PORT_WIDTH
) (
	input  wire logic                i_clk,
	input  wire logic                i_rst_n,
	// Software side: direction and data writes per port
	input  wire logic                i_first_dir_we,
	input  wire logic                i_first_data_we,
	input  wire logic                i_second_dir_we,
	input  wire logic                i_second_data_we,
	input  wire logic                i_third_dir_we,
	input  wire logic                i_third_data_we,
	input  wire logic [7:0]          i_wdata,
	// Alternate-function controls from peripherals
	input  wire logic                i_display_clk_en,
	input  wire logic                i_display_clock,
	input  wire logic                i_tone_en,
	input  wire logic                i_tone,
	input  wire logic [3:0]          i_cmp_sel,
	// Pads
	input  wire logic [FIRST_W-1:0]  i_first_port,
	input  wire logic [SECOND_W-1:0] i_second_port,
	input  wire logic [THIRD_W-1:0]  i_third_port,
	output logic      [FIRST_W-1:0]  o_first_port,
	output logic      [FIRST_W-1:0]  o_first_port_oe,
	output logic      [SECOND_W-1:0] o_second_port,
	output logic      [SECOND_W-1:0] o_second_port_oe,
	output logic      [THIRD_W-1:0]  o_third_port,
	output logic      [THIRD_W-1:0]  o_third_port_oe,
	// Read-back of pin levels
	output logic      [FIRST_W-1:0]  o_first_read,
	output logic      [SECOND_W-1:0] o_second_read,
	output logic      [THIRD_W-1:0]  o_third_read,
	// Alternate-function inputs toward peripherals
	output logic      [2:0]          o_ext_irq,
	output logic                     o_event_count_in,
	output logic      [7:0]          o_keyscan_in,
	output logic      [3:0]          o_comparator_in
);
	initial begin
		if (FIRST_W != 8 || SECOND_W != 8 || THIRD_W != 3)
			$error("port widths must be 8, 8 and 3");
	end

	logic [FIRST_W-1:0]  first_dir;
	logic [FIRST_W-1:0]  first_data;
	logic [FIRST_W-1:0]  first_pin;
	logic [SECOND_W-1:0] second_dir;
	logic [SECOND_W-1:0] second_data;
	logic [SECOND_W-1:0] second_pin;
	logic [THIRD_W-1:0]  third_dir;
	logic [THIRD_W-1:0]  third_data;
	logic [THIRD_W-1:0]  third_pin;
	logic [FIRST_W-1:0]  next_first_out;
	logic [FIRST_W-1:0]  next_first_oe;
	logic [SECOND_W-1:0] next_second_out;
	logic [SECOND_W-1:0] next_second_oe;
	pin_role_t [3:0]     cmp_role;

	port_bank #(.WIDTH(FIRST_W)) u_first (
		.i_clk        (i_clk),
		.i_rst_n      (i_rst_n),
		.i_dir_we     (i_first_dir_we),
		.i_dir_wdata  (i_wdata[FIRST_W-1:0]),
		.i_data_we    (i_first_data_we),
		.i_data_wdata (i_wdata[FIRST_W-1:0]),
		.i_pad_in     (i_first_port),
		.o_dir        (first_dir),
		.o_data       (first_data),
		.o_pin_in     (first_pin)
	);

	port_bank #(.WIDTH(SECOND_W)) u_second (
		.i_clk        (i_clk),
		.i_rst_n      (i_rst_n),
		.i_dir_we     (i_second_dir_we),
		.i_dir_wdata  (i_wdata[SECOND_W-1:0]),
		.i_data_we    (i_second_data_we),
		.i_data_wdata (i_wdata[SECOND_W-1:0]),
		.i_pad_in     (i_second_port),
		.o_dir        (second_dir),
		.o_data       (second_data),
		.o_pin_in     (second_pin)
	);

	port_bank #(.WIDTH(THIRD_W)) u_third (
		.i_clk        (i_clk),
		.i_rst_n      (i_rst_n),
		.i_dir_we     (i_third_dir_we),
		.i_dir_wdata  (i_wdata[THIRD_W-1:0]),
		.i_data_we    (i_third_data_we),
		.i_data_wdata (i_wdata[THIRD_W-1:0]),
		.i_pad_in     (i_third_port),
		.o_dir        (third_dir),
		.o_data       (third_data),
		.o_pin_in     (third_pin)
	);

	// First port drive; display clock overrides data on its pin
	always_comb begin
		next_first_out = first_data;
		next_first_oe  = first_dir;
		if (i_display_clk_en) begin
			next_first_out[`DISPLAY_CLK_BIT] = i_display_clock;
			next_first_oe[`DISPLAY_CLK_BIT]  = 1'b1;
		end
	end

	// Second port drive; tone takes its pin only while enabled
	always_comb begin
		next_second_out = second_data;
		next_second_oe  = second_dir;
		if (i_tone_en) begin
			next_second_out[`TONE_BIT] = i_tone;
			next_second_oe[`TONE_BIT]  = 1'b1;
		end
	end

	// Pad drive registered so outputs come straight from flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_first_port     <= `DATA_RESET_8;
			o_first_port_oe  <= `DIR_RESET_8;
			o_second_port    <= `DATA_RESET_8;
			o_second_port_oe <= `DIR_RESET_8;
			o_third_port     <= `DATA_RESET_3;
			o_third_port_oe  <= `DIR_RESET_3;
		end else begin
			o_first_port     <= next_first_out;
			o_first_port_oe  <= next_first_oe;
			o_second_port    <= next_second_out;
			o_second_port_oe <= next_second_oe;
			o_third_port     <= third_data;
			o_third_port_oe  <= third_dir;
		end
	end

	// Read-back always sees the pad, whatever role it plays
	// read-back ignores roles
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_first_read  <= '0;
			o_second_read <= '0;
			o_third_read  <= '0;
		end else begin
			o_first_read  <= first_pin;
			o_second_read <= second_pin;
			o_third_read  <= third_pin;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ext_irq        <= 3'h0;
			o_event_count_in <= 1'b0;
		end else begin
			o_ext_irq        <= first_pin[2:0];
			o_event_count_in <= first_pin[`EVENT_BIT];
		end
	end

	// Role of each comparator-capable pin
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cmp_role
			assign cmp_role[g] = i_cmp_sel[g] ? ROLE_ALT : ROLE_KEYSCAN;
		end
	endgenerate

	// key-scan taps; a pin in its other role reads released (high)
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_keyscan_in    <= `KEYSCAN_RESET;
			o_comparator_in <= 4'h0;
		end else begin
			o_keyscan_in[2:0] <= second_pin[2:0];
			o_keyscan_in[3]   <= i_tone_en ? 1'b1 : second_pin[`TONE_BIT];
			for (int k = 0; k < 4; k++) begin
				o_keyscan_in[`CMP_LOW_BIT+k] <= (cmp_role[k] == ROLE_ALT) ?
					1'b1 : second_pin[`CMP_LOW_BIT+k];
				o_comparator_in[k] <= (cmp_role[k] == ROLE_ALT) ?
					second_pin[`CMP_LOW_BIT+k] : 1'b0;
			end
		end
	end

	dir_reset_a: assert property (@(posedge i_clk)
		$rose(i_rst_n) |-> (o_first_port_oe == 8'h00 && o_second_port_oe == 8'h00
			&& o_third_port_oe == 3'h0))
		else $error("pin enabled right after reset");

	first_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_first_dir_we && !i_display_clk_en ##1 !i_display_clk_en |=>
		o_first_port_oe == $past(i_wdata, 2))
		else $error("first port enable does not follow direction write");

	second_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_second_dir_we && !i_tone_en ##1 !i_tone_en |=>
		o_second_port_oe == $past(i_wdata, 2))
		else $error("second port enable does not follow direction write");

	third_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_third_dir_we |-> ##2 o_third_port_oe == $past(i_wdata[2:0], 2))
		else $error("third port enable does not follow direction write");

	// interrupt lines track pins
	// Start only once reset is sampled high: the pin flop still clears on the release edge
	ext_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n |-> ##2 o_ext_irq == $past(i_first_port[2:0], 2))
		else $error("interrupt lines do not follow pins");

	disp_clk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n && i_display_clk_en |=>
		o_first_port_oe[6] && o_first_port[6] == $past(i_display_clock))
		else $error("display clock not on pin");

	keyscan_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n |-> ##2 o_keyscan_in[2:0] == $past(i_second_port[2:0], 2))
		else $error("key-scan low bits do not follow pins");

	tone_pin_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n && i_tone_en |=> o_second_port_oe[3] && o_second_port[3] == $past(i_tone))
		else $error("tone not on pin");

	cmp_route_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n && i_cmp_sel[0] ##1 i_cmp_sel[0] |=>
		o_comparator_in[0] == $past(i_second_port[4], 2)
		&& o_keyscan_in[4])
		else $error("comparator role misrouted");

	readback_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n |-> ##2 o_second_read == $past(i_second_port, 2))
		else $error("read-back disturbed by alternate role");
endmodule // port_pin_alternate_mux
`default_nettype wire

// >>> hdl/port_mux_params.svh
// Constants for the general-purpose port and alternate-function mux
`ifndef PORT_MUX_PARAMS_SVH
`define PORT_MUX_PARAMS_SVH
`define FIRST_PORT_WIDTH   8
`define SECOND_PORT_WIDTH  8
`define THIRD_PORT_WIDTH   3
`define DIR_RESET_8        8'h00
`define DIR_RESET_3        3'h0
`define DATA_RESET_8       8'h00
`define DATA_RESET_3       3'h0
`define EVENT_BIT          3
`define DISPLAY_CLK_BIT    6
`define TONE_BIT           3
`define CMP_LOW_BIT        4
`define KEYSCAN_RESET      8'hff
`endif

// >>> hdl/port_mux_pkg.sv
// Types shared by the port mux design
package port_mux_pkg;
	// Role of a shared second-port pin
	typedef enum logic {
		ROLE_KEYSCAN = 1'b0,
		ROLE_ALT     = 1'b1
	} pin_role_t;
endpackage

// >>> hdl/port_bank.sv
// One bidirectional port bank: direction and data latches plus pad signals
`timescale 1ns/1ps
`default_nettype none
module port_bank #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_dir_we,
	input  wire logic [WIDTH-1:0] i_dir_wdata,
	input  wire logic             i_data_we,
	input  wire logic [WIDTH-1:0] i_data_wdata,
	input  wire logic [WIDTH-1:0] i_pad_in,
	output logic      [WIDTH-1:0] o_dir,
	output logic      [WIDTH-1:0] o_data,
	output logic      [WIDTH-1:0] o_pin_in
);
	initial begin
		if (WIDTH < 1 || WIDTH > 8)
			$error("port_bank width out of range");
	end

	// Direction latch, cleared so pins float as inputs after reset
	// direction clears at reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_dir <= '0;
		else if (i_dir_we)
			o_dir <= i_dir_wdata;
	end

	// Output data latch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_data <= '0;
		else if (i_data_we)
			o_data <= i_data_wdata;
	end

	// Registered pin sample, one cycle of latency
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_pin_in <= '0;
		else
			o_pin_in <= i_pad_in;
	end
endmodule // port_bank
`default_nettype wire

// >>> test/board_pins.sv
// Board model: each pad follows the chip when driven, else the board
`timescale 1ns/1ps
`default_nettype none
module board_pins #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] i_out,
	input  wire logic [W-1:0] i_oe,
	input  wire logic [W-1:0] i_drive,
	output logic      [W-1:0] o_pad
);
	assign o_pad = (i_oe & i_out) | (~i_oe & i_drive);
endmodule // board_pins
`default_nettype wire

// >>> test/tb_port_pin_alternate_mux.sv
// Bench: random writes and pad levels against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_port_pin_alternate_mux;
	logic       i_clk = 1'b0;
	logic       i_rst_n = 1'b0;
	logic [5:0] we = 6'h00;
	logic [7:0] wd = 8'h00, b1 = 8'h00, b2 = 8'h00;
	logic [2:0] b3 = 3'h0;
	logic       dce = 1'b0, dck = 1'b0, ten = 1'b0, tn = 1'b0;
	logic [3:0] cs = 4'h0;
	logic [7:0] o1, e1, o2, e2, p1, p2, rb1, rb2, ks, m_dir [3], m_dat [3];
	logic [2:0] o3, e3, p3, rb3, irq;
	logic [3:0] cmp;
	logic       evt;
	logic [31:0] seed = 32'h3612;
	int         err_total = 0;
	int         n_checks = 0;
	always #12.5 i_clk = ~i_clk;
	port_pin_alternate_mux dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_first_dir_we(we[0]), .i_first_data_we(we[1]), .i_second_dir_we(we[2]),
		.i_second_data_we(we[3]), .i_third_dir_we(we[4]), .i_third_data_we(we[5]),
		.i_wdata(wd), .i_display_clk_en(dce), .i_display_clock(dck), .i_tone_en(ten),
		.i_tone(tn), .i_cmp_sel(cs), .i_first_port(p1), .i_second_port(p2),
		.i_third_port(p3), .o_first_port(o1), .o_first_port_oe(e1), .o_second_port(o2),
		.o_second_port_oe(e2), .o_third_port(o3), .o_third_port_oe(e3),
		.o_first_read(rb1), .o_second_read(rb2), .o_third_read(rb3), .o_ext_irq(irq),
		.o_event_count_in(evt), .o_keyscan_in(ks), .o_comparator_in(cmp));
	board_pins #(.W(8)) bp1 (.i_out(o1), .i_oe(e1), .i_drive(b1), .o_pad(p1));
	board_pins #(.W(8)) bp2 (.i_out(o2), .i_oe(e2), .i_drive(b2), .o_pad(p2));
	board_pins #(.W(3)) bp3 (.i_out(o3), .i_oe(e3), .i_drive(b3), .o_pad(p3));
	// Galois step; tap set is arbitrary but maximal length
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
	endfunction
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		n_checks++;
		if (got !== ex) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic wrap_up();
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One write strobe set; model takes the same data
	task automatic wr(input logic [5:0] w, input logic [7:0] d);
		@(posedge i_clk);
		we <= w;
		wd <= d;
		for (int k = 0; k < 3; k++) begin
			if (w[2*k]) m_dir[k] = d;
			if (w[2*k+1]) m_dat[k] = d;
		end
	endtask
	// Settled comparison of every output against the model
	task automatic check_all();
		logic [7:0] a1, q1, a2, q2, d1, d2;
		logic [2:0] d3;
		a1 = m_dir[0] | {1'b0, dce, 6'h00};
		q1 = dce ? {m_dat[0][7], dck, m_dat[0][5:0]} : m_dat[0];
		a2 = m_dir[1] | {4'h0, ten, 3'h0};
		q2 = ten ? {m_dat[1][7:4], tn, m_dat[1][2:0]} : m_dat[1];
		d1 = (a1 & q1) | (~a1 & b1);
		d2 = (a2 & q2) | (~a2 & b2);
		d3 = (m_dir[2][2:0] & m_dat[2][2:0]) | (~m_dir[2][2:0] & b3);
		chk("first_oe", a1, e1);
		chk("first_out", a1 & q1, a1 & o1);
		chk("second_oe", a2, e2);
		chk("second_out", a2 & q2, a2 & o2);
		chk("third_oe", {5'h00, m_dir[2][2:0]}, {5'h00, e3});
		chk("third_out", {5'h00, d3}, {5'h00, e3 & o3 | ~e3 & b3});
		chk("first_read", d1, rb1);
		chk("second_read", d2, rb2);
		chk("third_read", {5'h00, d3}, {5'h00, rb3});
		chk("ext_irq", {4'h0, d1[3:0]}, {4'h0, evt, irq});
		chk("keyscan", d2 | {cs, ten, 3'h0}, ks);
		chk("comparator", {4'h0, cs & d2[7:4]}, {4'h0, cmp});
	endtask
	// Hang guard, well beyond the expected run
	initial begin
		#500000;
		err_total++;
		wrap_up();
	end
	initial begin
		for (int k = 0; k < 3; k++) begin
			m_dir[k] = 8'h00;
			m_dat[k] = 8'h00;
		end
		repeat (5) @(posedge i_clk);
		#1;
		chk("reset_oe", 8'h00, e1 | e2 | {5'h00, e3});
		chk("reset_keyscan", 8'hff, ks);
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 80; i++) begin
			// Random inputs change on a rising edge, by non-blocking assignment
			@(posedge i_clk);
			seed = lfsr(seed);
			b1 <= seed[7:0];
			b2 <= seed[15:8];
			b3 <= seed[18:16];
			{dce, dck, ten, tn} <= seed[22:19];
			cs <= seed[26:23];
			// Back-to-back writes, often on several ports at once
			wr(seed[31:26], seed[11:4]);
			seed = lfsr(seed);
			wr(seed[5:0], seed[15:8]);
			@(posedge i_clk);
			we <= 6'h00;
			if (i == 40) begin
				i_rst_n <= 1'b0;
				for (int k = 0; k < 3; k++) begin
					m_dir[k] = 8'h00;
					m_dat[k] = 8'h00;
				end
				@(posedge i_clk);
				i_rst_n <= 1'b1;
				#1;
				chk("reset_oe", 8'h00, e1 | e2 | {5'h00, e3});
				chk("reset_keyscan", 8'hff, ks);
			end
			repeat (4) @(posedge i_clk);
			#1;
			check_all();
		end
		wrap_up();
	end
endmodule // tb_port_pin_alternate_mux
`default_nettype wire
